/* bench/ihpb_port_asserts.sv */
// checker: host port answer timing and tx slot behaviour
`timescale 1ns/100ps
module ihpb_port_asserts #(
  parameter int MEM_AW = 14
) (
  // watched ports
  input wire logic              clock_in,
  input wire logic              rst_b_in,
  input wire logic [9:0]        io_addr_in,
  input wire logic              io_rd_b_in,
  input wire logic              io_wr_b_in,
  input wire logic              host_data_oe_out,
  input wire logic              soft_reset_in,
  input wire logic              tx_start_out,
  input wire logic              tx_slot_out,
  input wire logic              tx_done_in,
  input wire logic [MEM_AW-1:0] tx_rd_addr_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  logic [3:0] wr_age;
  // cycles since the last write strobe
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) wr_age <= 4'hf;
    else if (!io_wr_b_in) wr_age <= 4'h0;
    else if (wr_age != 4'hf) wr_age <= wr_age + 4'h1;
  end
  a_oe_base_match: assert property ($rose(host_data_oe_out) |->
    io_addr_in[9:7] == 3'h6 && io_addr_in[3:0] == 4'h0) else $error("answer outside io window");
  a_oe_release: assert property ($rose(io_rd_b_in) |-> ##[1:5] !host_data_oe_out)
    else $error("read data held too long");
  a_oe_write_quiet: assert property ((!io_wr_b_in && io_rd_b_in) [*3] |-> !host_data_oe_out)
    else $error("bus driven during write");
  a_start_pulse: assert property (tx_start_out |=> !tx_start_out)
    else $error("start longer than one cycle");
  a_start_after_write: assert property (tx_start_out |-> wr_age < 4'h8)
    else $error("start without host write");
  a_done_toggles: assert property (tx_done_in && !soft_reset_in |-> ##2
    tx_slot_out != $past(tx_slot_out, 2)) else $error("slot kept after done");
  a_slot_cause: assert property ($changed(tx_slot_out) |->
    $past(tx_done_in, 2) || $past(soft_reset_in, 2)) else $error("slot moved without cause");
  a_soft_reset_tx: assert property (soft_reset_in |-> ##2
    !tx_slot_out && tx_rd_addr_out == '0) else $error("tx start not reset");
  c_start: cover property (tx_start_out);
  c_done_two: cover property (tx_done_in && tx_slot_out);
  c_read: cover property ($rose(host_data_oe_out));
endmodule // ihpb_port_asserts

bind ihpb_port ihpb_port_asserts #(.MEM_AW(MEM_AW)) u_chk (.*);

/* bench/ihpb_tx_engine_model.sv */
// partner: transmit engine answering start with done after a random delay
`timescale 1ns/100ps
module ihpb_tx_engine_model (
  // engine side
  input wire logic  clock_in,
  input wire logic  tx_start_in,
  input wire logic  tx_slot_in,
  output logic      tx_done_out,
  output logic [7:0] tx_status_out
);
  int wait_n;
  initial begin
    tx_done_out = 1'b0;
    tx_status_out = 8'h00;
    forever begin
      @(posedge clock_in);
      if (tx_start_in) begin
        wait_n = $urandom_range(40, 1);
        repeat (wait_n) @(posedge clock_in);
        tx_done_out <= 1'b1;
        tx_status_out <= 8'h80 | {7'h0, tx_slot_in};
        @(posedge clock_in);
        tx_done_out <= 1'b0;
        tx_status_out <= ~tx_status_out;
      end
    end
  end
endmodule // ihpb_tx_engine_model

/* bench/tb_indexed_host_packet_buffer_port.sv */
// testbench: host port, tx slots, rx ring and memory window
`timescale 1ns/100ps
module tb_indexed_host_packet_buffer_port;
  logic clock_in = 1'b0, rst_b_in = 1'b0, io_rd_b_in = 1'b1, io_wr_b_in = 1'b1;
  logic port_sel_in = 1'b0, soft_reset_in = 1'b0, base_from_eeprom_in = 1'b0;
  logic eeprom_base_valid_in = 1'b0, host_data_oe_out, tx_start_out, tx_slot_out;
  logic tx_crc_en_out, tx_pad_en_out, tx_done_in;
  logic [2:0] base_strap_in = 3'h0, eeprom_base_in = 3'h0;
  logic [9:0] io_addr_in = 10'h000, base;
  logic [31:0] host_data_in = 32'h0, host_data_out, rv;
  logic [15:0] tx_length_out, ln;
  logic [7:0] tx_done_status_in, rx_status_in = 8'h00, d [6];
  logic [13:0] tx_rd_addr_out;
  logic [18:0] seen;
  ihpb_pkg::ihpb_rx_byte_t rx_byte_in = '0;
  int n_errors = 0, check_count = 0, cyc = 0;
  always #5 clock_in = ~clock_in;
  ihpb_port #(.MEM_AW(14)) u_dut (.*);
  ihpb_tx_engine_model u_eng (.clock_in(clock_in), .tx_start_in(tx_start_out),
    .tx_slot_in(tx_slot_out), .tx_done_out(tx_done_in), .tx_status_out(tx_done_status_in));
  always @(posedge clock_in) begin
    if (tx_start_out) seen <= {tx_slot_out, tx_crc_en_out, tx_pad_en_out, tx_length_out};
  end
  function automatic logic [31:0] f_hdr(input logic [15:0] n, input logic [7:0] s);
    return {n, s, 8'h01};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic rd, input logic sel, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock_in);
    io_addr_in <= base;
    port_sel_in <= sel;
    host_data_in <= wd;
    if (rd) io_rd_b_in <= 1'b0;
    else io_wr_b_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    while (rd && host_data_oe_out !== 1'b1 && n < 12) begin
      @(posedge clock_in);
      n++;
    end
    rv = host_data_out;
    io_rd_b_in <= 1'b1;
    io_wr_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
  endtask
  task automatic wreg(input logic [7:0] i, input logic [31:0] v);
    acc(1'b0, 1'b0, {24'h0, i});
    acc(1'b0, 1'b1, v);
  endtask
  task automatic rreg(input logic [7:0] i);
    acc(1'b0, 1'b0, {24'h0, i});
    acc(1'b1, 1'b1, 32'h0);
  endtask
  task automatic maddr(input logic [13:0] a);
    wreg(ihpb_pkg::IDX_MEM_ADDR_LO, {24'h0, a[7:0]});
    wreg(ihpb_pkg::IDX_MEM_ADDR_HI, {26'h0, a[13:8]});
    rreg(ihpb_pkg::IDX_MEM_PREFETCH);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      test_done;
    end
  end
  initial begin
    void'($urandom(32'h17b03bf4));
    base_strap_in = 3'($urandom_range(7, 0));
    base = 10'h300 + {3'h0, base_strap_in, 4'h0};
    rx_status_in = 8'($urandom);
    foreach (d[i]) d[i] = 8'($urandom);
    repeat (16) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    base = base ^ 10'h040;
    rreg(ihpb_pkg::IDX_TX_CONTROL);
    chk("foreign base", 32'h0, {31'h0, host_data_oe_out});
    base = base ^ 10'h040;
    rreg(8'h80);
    chk("unmapped index", 32'h0, rv);
    $display("test refused done");
    for (int k = 0; k < 5; k++) begin
      ln = 16'($urandom_range(1514, 60));
      seen = '0;
      wreg(ihpb_pkg::IDX_TX_LEN_LOW, {24'h0, ln[7:0]});
      wreg(ihpb_pkg::IDX_TX_LEN_HIGH, {24'h0, ln[15:8]});
      wreg(ihpb_pkg::IDX_TX_CONTROL, {28'h0, 2'(k), 2'h2});
      chk("start fields", {13'h0, k[0], ~k[0], ~k[1], ln}, {13'h0, seen});
      rv = 32'h2;
      for (int n = 0; n < 20 && rv[1] !== 1'b0; n++) rreg(ihpb_pkg::IDX_TX_CONTROL);
      chk("request bit", 32'h0, {30'h0, rv[1], 1'b0});
      rreg(k[0] ? ihpb_pkg::IDX_TX_STAT_TWO : ihpb_pkg::IDX_TX_STAT_ONE);
      chk("slot status", {24'h0, 7'h40, k[0]}, {24'h0, rv[7:0]});
    end
    $display("test tx slots done");
    @(posedge clock_in) soft_reset_in <= 1'b1;
    @(posedge clock_in) soft_reset_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    chk("soft reset tx", 32'h0, {17'h0, tx_slot_out, tx_rd_addr_out});
    wreg(ihpb_pkg::IDX_BUS_MODE, 32'h2);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_in);
      rx_byte_in <= '{valid: 1'b1, last: i == 5, data: d[i]};
    end
    @(posedge clock_in);
    rx_byte_in <= '0;
    rreg(ihpb_pkg::IDX_RX_WPTR_LO);
    ln[7:0] = rv[7:0];
    rreg(ihpb_pkg::IDX_RX_WPTR_HI);
    chk("rx next start", 32'h0c10, {18'h0, rv[5:0], ln[7:0]});
    maddr(14'h0c00);
    rreg(ihpb_pkg::IDX_MEM_DATA);
    chk("rx header", f_hdr(16'h6, rx_status_in), rv);
    acc(1'b1, 1'b1, 32'h0);
    chk("rx data word", {d[3], d[2], d[1], d[0]}, rv);
    $display("test rx ring done");
    wreg(ihpb_pkg::IDX_BUS_MODE, 32'h0);
    wreg(ihpb_pkg::IDX_INT_MASK, 32'h80);
    wreg(ihpb_pkg::IDX_MEM_ADDR_LO, 32'hff);
    wreg(ihpb_pkg::IDX_MEM_ADDR_HI, 32'h0b);
    wreg(ihpb_pkg::IDX_MEM_DATA, {24'h0, d[4]});
    acc(1'b0, 1'b1, {24'h0, d[5]});
    maddr(14'h0000);
    rreg(ihpb_pkg::IDX_MEM_DATA);
    chk("write wrap", {24'h0, d[5]}, {24'h0, rv[7:0]});
    maddr(14'h3fff);
    rreg(ihpb_pkg::IDX_MEM_DATA);
    acc(1'b1, 1'b1, 32'h0);
    chk("read wrap", 32'h01, {24'h0, rv[7:0]});
    $display("test wrap done");
    test_done;
  end
endmodule // tb_indexed_host_packet_buffer_port

/* rtl/ihpb_mem.sv */
// file: packet memory with registered read port and a single byte-wide write port
`timescale 1ns/100ps
module ihpb_mem #(
  parameter int AW = 14
) (
  // clock
  input  wire logic          clock_in,
  // write side
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [7:0]    wdata_in,
  // read side
  input  wire logic [AW-1:0] raddr_in,
  output logic [7:0]         rdata_out
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clock_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    rdata_out <= mem[raddr_in];
  end
endmodule // ihpb_mem

/* rtl/ihpb_pkg.sv */
// package: constants and carrier types for the indexed host packet buffer port
package ihpb_pkg;
  // host i/o window
  localparam logic [9:0]  IO_BASE_FIRST   = 10'h300;
  localparam logic [9:0]  IO_BASE_STEP    = 10'h010;
  localparam int          IO_BASE_COUNT   = 8;
  // register indexes
  localparam logic [7:0]  IDX_TX_CONTROL  = 8'h02;
  localparam logic [7:0]  IDX_TX_STAT_ONE = 8'h03;
  localparam logic [7:0]  IDX_TX_STAT_TWO = 8'h04;
  localparam logic [7:0]  IDX_TX_LEN_LOW  = 8'hfc;
  localparam logic [7:0]  IDX_TX_LEN_HIGH = 8'hfd;
  localparam logic [7:0]  IDX_INT_MASK    = 8'hff;
  localparam logic [7:0]  IDX_MEM_ADDR_LO = 8'hf4;
  localparam logic [7:0]  IDX_MEM_ADDR_HI = 8'hf5;
  localparam logic [7:0]  IDX_MEM_PREFETCH = 8'hf0;
  localparam logic [7:0]  IDX_MEM_DATA    = 8'hf2;
  localparam logic [7:0]  IDX_RX_WPTR_LO  = 8'h24;
  localparam logic [7:0]  IDX_RX_WPTR_HI  = 8'h25;
  localparam logic [7:0]  IDX_TX_PTR_LO   = 8'h22;
  localparam logic [7:0]  IDX_TX_PTR_HI   = 8'h23;
  localparam logic [7:0]  IDX_BUS_MODE    = 8'hfe;
  // field positions
  localparam int          TXC_REQ_BIT     = 1;
  localparam int          TXC_NO_CRC_BIT  = 2;
  localparam int          TXC_NO_PAD_BIT  = 3;
  localparam int          IMR_WRAP_BIT    = 7;
  localparam int          TXS_DONE_BIT    = 7;
  // memory map
  localparam int          MEM_AW          = 14;
  localparam logic [13:0] TX_AREA_END     = 14'h0c00;
  localparam logic [13:0] RX_RING_START   = 14'h0c00;
  localparam logic [13:0] TX_START_RESET  = 14'h0000;
  localparam logic [7:0]  RX_HDR_MARK     = 8'h01;
  // reset values
  localparam logic [7:0]  TXC_RESET       = 8'h00;
  localparam logic [7:0]  IMR_RESET       = 8'h00;
  localparam logic [1:0]  BUS_MODE_RESET  = 2'h0;
  // bus width modes
  typedef enum logic [1:0] {
    IHPB_BW8  = 2'h0,
    IHPB_BW16 = 2'h1,
    IHPB_BW32 = 2'h2
  } ihpb_bw_t;
  // host access carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        port_data;
    logic [31:0] wdata;
  } ihpb_host_t;
  // receive byte carrier
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } ihpb_rx_byte_t;
endpackage

/* rtl/ihpb_port.sv */
// file: indexed host port, packet buffer pointers and tx slot control
//
// Contract
// - decode eight io bases 300h..370h
// - base from straps or serial memory
// - select low index, high data port
// - dummy access loads the data buffer
// - advance by bus width, prefetch next
// - 16k memory, 3k tx, 13k rx
// - write wrap to zero at 3k
// - read wrap to 0c00h at 16k
// - two tx slots, status 03h/04h
// - tx control picks crc and pad
// - reset: tx start zero, slot one
// - request starts slot when not busy, writes continue
// - rx ring starts at 0c00h
// - rx header 01h, status, length
// - rx packet start aligned to width
`timescale 1ns/100ps
module ihpb_port #(
  parameter int MEM_AW = 14
) (
  // clock and reset
  input  wire logic                   clock_in,
  input  wire logic                   rst_b_in,
  // host bus pins
  input  wire logic [9:0]             io_addr_in,
  input  wire logic                   io_rd_b_in,
  input  wire logic                   io_wr_b_in,
  input  wire logic                   port_sel_in,
  input  wire logic [31:0]            host_data_in,
  output logic      [31:0]            host_data_out,
  output logic                        host_data_oe_out,
  // base selection and soft reset
  input  wire logic [2:0]             base_strap_in,
  input  wire logic                   base_from_eeprom_in,
  input  wire logic [2:0]             eeprom_base_in,
  input  wire logic                   eeprom_base_valid_in,
  input  wire logic                   soft_reset_in,
  // transmit engine
  output logic                        tx_start_out,
  output logic                        tx_slot_out,
  output logic [15:0]                 tx_length_out,
  output logic                        tx_crc_en_out,
  output logic                        tx_pad_en_out,
  input  wire logic                   tx_done_in,
  input  wire logic [7:0]             tx_done_status_in,
  output logic [MEM_AW-1:0]           tx_rd_addr_out,
  // receive engine
  input  wire ihpb_pkg::ihpb_rx_byte_t rx_byte_in,
  input  wire logic [7:0]             rx_status_in
);
  // pin synchronisers
  logic [2:0] rd_sync_reg;
  logic [2:0] wr_sync_reg;
  logic [1:0] sel_sync_reg;
  logic [9:0] addr_s1_reg;
  logic [9:0] addr_s2_reg;
  logic [31:0] din_s1_reg;
  logic [31:0] din_s2_reg;
  logic [2:0] strap_s1_reg;
  logic [2:0] strap_s2_reg;
  logic [1:0] eesel_sync_reg;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_sync_reg    <= 3'h7;
      wr_sync_reg    <= 3'h7;
      sel_sync_reg   <= 2'h0;
      addr_s1_reg    <= 10'h000;
      addr_s2_reg    <= 10'h000;
      din_s1_reg     <= 32'h0;
      din_s2_reg     <= 32'h0;
      strap_s1_reg   <= 3'h0;
      strap_s2_reg   <= 3'h0;
      eesel_sync_reg <= 2'h0;
    end else begin
      rd_sync_reg    <= {rd_sync_reg[1:0], io_rd_b_in};
      wr_sync_reg    <= {wr_sync_reg[1:0], io_wr_b_in};
      sel_sync_reg   <= {sel_sync_reg[0], port_sel_in};
      addr_s1_reg    <= io_addr_in;
      addr_s2_reg    <= addr_s1_reg;
      din_s1_reg     <= host_data_in;
      din_s2_reg     <= din_s1_reg;
      strap_s1_reg   <= base_strap_in;
      strap_s2_reg   <= strap_s1_reg;
      eesel_sync_reg <= {eesel_sync_reg[0], base_from_eeprom_in};
    end
  end

  // base select capture after reset release
  logic [2:0] base_sel_reg;
  logic [1:0] base_caught_reg;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      base_sel_reg    <= 3'h0;
      base_caught_reg <= 2'h0;
    end else if (eesel_sync_reg[1] && eeprom_base_valid_in) begin
      base_sel_reg    <= eeprom_base_in;
      base_caught_reg <= 2'h3;
    end else if (base_caught_reg != 2'h3) begin
      base_sel_reg    <= strap_s2_reg;
      base_caught_reg <= base_caught_reg + 2'h1;
    end
  end

  logic hit;
  assign hit = (addr_s2_reg[9:4] == 6'(({7'h0, base_sel_reg} + 10'h030)))
               && (addr_s2_reg[3:0] == 4'h0);
  logic rd_edge;
  logic wr_edge;
  assign rd_edge = hit && rd_sync_reg[2] && !rd_sync_reg[1];
  assign wr_edge = hit && wr_sync_reg[2] && !wr_sync_reg[1];
  logic data_port;
  assign data_port = sel_sync_reg[1];

  // registers
  logic [7:0]        index_reg;
  logic [7:0]        tx_control_reg;
  logic [7:0]        tx_status_slot_one_reg;
  logic [7:0]        tx_status_slot_two_reg;
  logic [7:0]        tx_length_low_reg;
  logic [7:0]        tx_length_high_reg;
  logic [7:0]        interrupt_mask_reg;
  logic [1:0]        bus_mode_reg;
  logic [MEM_AW-1:0] mem_addr_reg;
  logic [MEM_AW-1:0] rx_wptr_reg;
  logic [MEM_AW-1:0] tx_start_reg;
  logic              tx_slot_reg;
  logic              tx_busy_reg;
  logic [31:0]       data_buf_reg;

  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  assign idx_wr = wr_edge && !data_port;
  assign dat_wr = wr_edge && data_port;
  assign dat_rd = rd_edge && data_port;

  // index names the data port register
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      index_reg <= 8'h00;
    end else if (idx_wr) begin
      index_reg <= din_s2_reg[7:0];
    end
  end

  function automatic logic [2:0] width_bytes(input logic [1:0] mode);
    unique case (mode)
      ihpb_pkg::IHPB_BW16: width_bytes = 3'd2;
      ihpb_pkg::IHPB_BW32: width_bytes = 3'd4;
      default:             width_bytes = 3'd1;
    endcase
  endfunction

  function automatic logic [MEM_AW-1:0] align_up(input logic [MEM_AW-1:0] a,
                                                 input logic [1:0] mode);
    logic [MEM_AW-1:0] m;
    m = MEM_AW'(width_bytes(mode)) - MEM_AW'(1);
    align_up = (a + m) & ~m;
  endfunction

  // memory write staging: one byte lane per cycle
  logic [31:0]       wr_data_reg;
  logic [2:0]        wr_left_reg;
  logic [MEM_AW-1:0] wr_addr_reg;
  logic [2:0]        rd_lane_reg;
  logic [2:0]        rd_left_reg;
  logic              mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [7:0]        mem_wdata;
  logic [MEM_AW-1:0] mem_raddr;
  logic [7:0]        mem_rdata;
  logic [2:0]        rx_hdr_step_reg;
  logic              rx_we;
  assign rx_we = rx_byte_in.valid;

  // address step with wrap
  function automatic logic [MEM_AW-1:0] next_addr(input logic [MEM_AW-1:0] a,
                                                  input logic [2:0] step,
                                                  input logic wrap_en,
                                                  input logic is_wr);
    logic [MEM_AW:0] s;
    s = {1'b0, a} + {(MEM_AW - 2)'(0), step};
    if (is_wr && wrap_en && s >= {1'b0, ihpb_pkg::TX_AREA_END}) begin
      next_addr = MEM_AW'(s - {1'b0, ihpb_pkg::TX_AREA_END});
    end else if (!is_wr && wrap_en && s[MEM_AW]) begin
      next_addr = ihpb_pkg::RX_RING_START + MEM_AW'(s);
    end else begin
      next_addr = MEM_AW'(s);
    end
  endfunction

  logic mem_data_acc;
  logic prefetch_acc;
  assign mem_data_acc = (dat_wr || dat_rd) && index_reg == ihpb_pkg::IDX_MEM_DATA;
  assign prefetch_acc = (dat_wr || dat_rd) && index_reg == ihpb_pkg::IDX_MEM_PREFETCH;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mem_addr_reg <= {MEM_AW{1'b0}};
    end else if (dat_wr && index_reg == ihpb_pkg::IDX_MEM_ADDR_LO) begin
      mem_addr_reg[7:0] <= din_s2_reg[7:0];
    end else if (dat_wr && index_reg == ihpb_pkg::IDX_MEM_ADDR_HI) begin
      mem_addr_reg[MEM_AW-1:8] <= din_s2_reg[MEM_AW-9:0];
    end else if (mem_data_acc) begin
      mem_addr_reg <= next_addr(mem_addr_reg, width_bytes(bus_mode_reg),
                                interrupt_mask_reg[ihpb_pkg::IMR_WRAP_BIT], dat_wr);
    end
  end

  // host byte writer
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_data_reg <= 32'h0;
      wr_left_reg <= 3'h0;
      wr_addr_reg <= {MEM_AW{1'b0}};
    end else if (dat_wr && index_reg == ihpb_pkg::IDX_MEM_DATA) begin
      wr_data_reg <= din_s2_reg;
      wr_left_reg <= width_bytes(bus_mode_reg);
      wr_addr_reg <= mem_addr_reg;
    end else if (wr_left_reg != 3'h0 && !rx_we && rx_hdr_step_reg == 3'h0) begin
      wr_data_reg <= {8'h00, wr_data_reg[31:8]};
      wr_left_reg <= wr_left_reg - 3'h1;
      wr_addr_reg <= next_addr(wr_addr_reg, 3'd1,
                               interrupt_mask_reg[ihpb_pkg::IMR_WRAP_BIT], 1'b1);
    end
  end

  // receive ring writer and header
  logic [MEM_AW-1:0] rx_pkt_start_reg;
  logic [15:0]       rx_count_reg;
  logic [7:0]        rx_hdr_byte;
  always_comb begin
    unique case (rx_hdr_step_reg)
      3'd1:    rx_hdr_byte = ihpb_pkg::RX_HDR_MARK;
      3'd2:    rx_hdr_byte = rx_status_in;
      3'd3:    rx_hdr_byte = rx_count_reg[7:0];
      default: rx_hdr_byte = rx_count_reg[15:8];
    endcase
  end
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_wptr_reg      <= ihpb_pkg::RX_RING_START;
      rx_pkt_start_reg <= ihpb_pkg::RX_RING_START;
      rx_count_reg     <= 16'h0;
      rx_hdr_step_reg  <= 3'h0;
    end else if (soft_reset_in) begin
      rx_wptr_reg      <= ihpb_pkg::RX_RING_START;
      rx_pkt_start_reg <= ihpb_pkg::RX_RING_START;
      rx_count_reg     <= 16'h0;
      rx_hdr_step_reg  <= 3'h0;
    end else if (rx_hdr_step_reg != 3'h0 && !rx_we) begin
      rx_hdr_step_reg <= (rx_hdr_step_reg == 3'd4) ? 3'h0 : rx_hdr_step_reg + 3'h1;
      if (rx_hdr_step_reg == 3'd4) begin
        rx_wptr_reg      <= align_up(rx_wptr_reg, bus_mode_reg);
        rx_pkt_start_reg <= align_up(rx_wptr_reg, bus_mode_reg);
        rx_count_reg     <= 16'h0;
      end
    end else if (rx_we) begin
      rx_wptr_reg  <= next_addr(rx_wptr_reg, 3'd1, 1'b1, 1'b0);
      rx_count_reg <= rx_count_reg + 16'h1;
      if (rx_byte_in.last) begin
        rx_hdr_step_reg <= 3'd1;
      end
    end else if (rx_count_reg == 16'h0 && rx_wptr_reg == rx_pkt_start_reg) begin
      // leave room for header
      rx_wptr_reg <= next_addr(rx_pkt_start_reg, 3'd4, 1'b1, 1'b0);
    end
  end

  // memory write mux: receive has priority
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = wr_addr_reg;
    mem_wdata = wr_data_reg[7:0];
    if (rx_we) begin
      mem_we    = 1'b1;
      mem_waddr = rx_wptr_reg;
      mem_wdata = rx_byte_in.data;
    end else if (rx_hdr_step_reg != 3'h0) begin
      mem_we    = 1'b1;
      mem_waddr = next_addr(rx_pkt_start_reg, rx_hdr_step_reg - 3'h1, 1'b1, 1'b0);
      mem_wdata = rx_hdr_byte;
    end else if (wr_left_reg != 3'h0) begin
      mem_we = 1'b1;
    end
  end

  logic [MEM_AW-1:0] rd_addr_reg;
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_lane_reg <= 3'h0;
      rd_left_reg <= 3'h0;
      rd_addr_reg <= {MEM_AW{1'b0}};
    end else if (mem_data_acc || prefetch_acc) begin
      rd_lane_reg <= 3'h0;
      rd_left_reg <= 3'd5;
      rd_addr_reg <= mem_data_acc ? next_addr(mem_addr_reg, width_bytes(bus_mode_reg),
                       interrupt_mask_reg[ihpb_pkg::IMR_WRAP_BIT], dat_wr) : mem_addr_reg;
    end else if (rd_left_reg != 3'h0) begin
      rd_left_reg <= rd_left_reg - 3'h1;
      rd_lane_reg <= rd_lane_reg + 3'h1;
      rd_addr_reg <= next_addr(rd_addr_reg, 3'd1, 1'b0, 1'b0);
    end
  end
  assign mem_raddr = rd_addr_reg;

  // data buffer fill, one byte per cycle
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_buf_reg <= 32'h0;
    end else if (rd_left_reg != 3'h0 && rd_left_reg != 3'd5) begin
      data_buf_reg[{rd_lane_reg[1:0] - 2'h1, 3'h0} +: 8] <= mem_rdata;
    end else if (rd_left_reg == 3'd5 && rd_lane_reg == 3'h0) begin
      data_buf_reg <= data_buf_reg;
    end
  end

  ihpb_mem #(
    .AW (MEM_AW)
  ) u_mem (
    .clock_in  (clock_in),
    .we_in     (mem_we),
    .waddr_in  (mem_waddr),
    .wdata_in  (mem_wdata),
    .raddr_in  (mem_raddr),
    .rdata_out (mem_rdata)
  );

  // control registers
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      interrupt_mask_reg <= ihpb_pkg::IMR_RESET;
      bus_mode_reg       <= ihpb_pkg::BUS_MODE_RESET;
      tx_length_low_reg  <= 8'h00;
      tx_length_high_reg <= 8'h00;
    end else if (dat_wr) begin
      unique case (index_reg)
        ihpb_pkg::IDX_INT_MASK:    interrupt_mask_reg <= din_s2_reg[7:0];
        ihpb_pkg::IDX_BUS_MODE:    bus_mode_reg       <= din_s2_reg[1:0];
        ihpb_pkg::IDX_TX_LEN_LOW:  tx_length_low_reg  <= din_s2_reg[7:0];
        ihpb_pkg::IDX_TX_LEN_HIGH: tx_length_high_reg <= din_s2_reg[7:0];
        default: ;
      endcase
    end
  end

  // tx control, slot sequencing and status
  logic tx_req_set;
  assign tx_req_set = dat_wr && index_reg == ihpb_pkg::IDX_TX_CONTROL
                      && din_s2_reg[ihpb_pkg::TXC_REQ_BIT];
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_control_reg         <= ihpb_pkg::TXC_RESET;
      tx_status_slot_one_reg <= 8'h00;
      tx_status_slot_two_reg <= 8'h00;
      tx_slot_reg            <= 1'b0;
      tx_busy_reg            <= 1'b0;
      tx_start_reg           <= ihpb_pkg::TX_START_RESET;
      tx_start_out           <= 1'b0;
    end else if (soft_reset_in) begin
      tx_slot_reg  <= 1'b0;
      tx_start_reg <= ihpb_pkg::TX_START_RESET;
      tx_busy_reg  <= 1'b0;
      tx_start_out <= 1'b0;
    end else begin
      tx_start_out <= 1'b0;
      if (dat_wr && index_reg == ihpb_pkg::IDX_TX_CONTROL) begin
        tx_control_reg <= din_s2_reg[7:0] | {6'h0, tx_control_reg[1], 1'b0};
      end
      if (tx_req_set && !tx_busy_reg) begin
        tx_busy_reg  <= 1'b1;
        tx_start_out <= 1'b1;
      end
      if (tx_done_in && tx_busy_reg) begin
        tx_busy_reg                               <= 1'b0;
        tx_control_reg[ihpb_pkg::TXC_REQ_BIT]      <= tx_req_set;
        tx_slot_reg                               <= ~tx_slot_reg;
        tx_start_reg <= align_up(tx_start_reg + MEM_AW'({tx_length_high_reg,
                                  tx_length_low_reg}), bus_mode_reg);
        if (tx_slot_reg) begin
          tx_status_slot_two_reg <= tx_done_status_in;
        end else begin
          tx_status_slot_one_reg <= tx_done_status_in;
        end
      end
    end
  end

  // register read mux
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    if (!data_port) begin
      rd_val = {24'h0, index_reg};
    end else begin
      unique case (index_reg)
        ihpb_pkg::IDX_TX_CONTROL:   rd_val = {24'h0, tx_control_reg};
        ihpb_pkg::IDX_TX_STAT_ONE:  rd_val = {24'h0, tx_status_slot_one_reg};
        ihpb_pkg::IDX_TX_STAT_TWO:  rd_val = {24'h0, tx_status_slot_two_reg};
        ihpb_pkg::IDX_TX_LEN_LOW:   rd_val = {24'h0, tx_length_low_reg};
        ihpb_pkg::IDX_TX_LEN_HIGH:  rd_val = {24'h0, tx_length_high_reg};
        ihpb_pkg::IDX_INT_MASK:     rd_val = {24'h0, interrupt_mask_reg};
        ihpb_pkg::IDX_BUS_MODE:     rd_val = {30'h0, bus_mode_reg};
        ihpb_pkg::IDX_MEM_ADDR_LO:  rd_val = {24'h0, mem_addr_reg[7:0]};
        ihpb_pkg::IDX_MEM_ADDR_HI:  rd_val = {26'h0, mem_addr_reg[MEM_AW-1:8]};
        ihpb_pkg::IDX_RX_WPTR_LO:   rd_val = {24'h0, rx_wptr_reg[7:0]};
        ihpb_pkg::IDX_RX_WPTR_HI:   rd_val = {26'h0, rx_wptr_reg[MEM_AW-1:8]};
        ihpb_pkg::IDX_TX_PTR_LO:    rd_val = {24'h0, tx_start_reg[7:0]};
        ihpb_pkg::IDX_TX_PTR_HI:    rd_val = {26'h0, tx_start_reg[MEM_AW-1:8]};
        ihpb_pkg::IDX_MEM_DATA,
        ihpb_pkg::IDX_MEM_PREFETCH: rd_val = data_buf_reg;
        default:                    rd_val = 32'h0;
      endcase
    end
  end

  // host data drive, held while read strobe low
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      host_data_out    <= 32'h0;
      host_data_oe_out <= 1'b0;
    end else begin
      if (rd_edge) begin
        host_data_out    <= rd_val;
        host_data_oe_out <= 1'b1;
      end else if (rd_sync_reg[1]) begin
        host_data_oe_out <= 1'b0;
      end
    end
  end

  // engine outputs
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_slot_out    <= 1'b0;
      tx_length_out  <= 16'h0;
      tx_crc_en_out  <= 1'b1;
      tx_pad_en_out  <= 1'b1;
      tx_rd_addr_out <= ihpb_pkg::TX_START_RESET;
    end else begin
      tx_slot_out    <= tx_slot_reg;
      tx_length_out  <= {tx_length_high_reg, tx_length_low_reg};
      if (dat_wr && index_reg == ihpb_pkg::IDX_TX_CONTROL) begin
        tx_crc_en_out <= ~din_s2_reg[ihpb_pkg::TXC_NO_CRC_BIT];
        tx_pad_en_out <= ~din_s2_reg[ihpb_pkg::TXC_NO_PAD_BIT];
      end
      tx_rd_addr_out <= tx_start_reg;
    end
  end
endmodule // ihpb_port
